// ---- src/internal_error_report.sv ----
`timescale 1ns/1ps
`default_nettype none

module internal_error_report (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// one-cycle report pulses
	input wire logic uncorr_pulse,
	input wire logic corr_pulse,
	// core configuration
	input wire logic [3:0] func_enable,
	input wire logic err_msg_enable,
	// aer status set and message requests
	output logic [3:0] aer_uncorr_set,
	output logic [3:0] aer_corr_set,
	output logic err_msg_uncorr,
	output logic err_msg_corr
);

	irq_decode_pkg::err_state_t state;
	irq_decode_pkg::err_state_t next_state;

	always_comb begin
		next_state = state;
		// every enabled function, not function-specific
		next_state.aer_uncorr_set = uncorr_pulse ? func_enable : 4'h0;
		next_state.err_msg_uncorr = uncorr_pulse & err_msg_enable;
		next_state.aer_corr_set = corr_pulse ? func_enable : 4'h0;
		next_state.err_msg_corr = corr_pulse & err_msg_enable;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state.aer_uncorr_set <= 4'h0;
			state.aer_corr_set <= 4'h0;
			state.err_msg_uncorr <= 1'b0;
			state.err_msg_corr <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign aer_uncorr_set = state.aer_uncorr_set;
	assign aer_corr_set = state.aer_corr_set;
	assign err_msg_uncorr = state.err_msg_uncorr;
	assign err_msg_corr = state.err_msg_corr;

endmodule

`default_nettype wire

// ---- src/irq_decode_consts.svh ----
`ifndef IRQ_DECODE_CONSTS_SVH
`define IRQ_DECODE_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LEGACY_STATUS_OFS 12'h160
`define LEGACY_MASK_OFS 12'h164
`define ERR_CTRL_OFS 12'h168
`define MSI_STATUS_LOW_OFS 12'h170
`define MSI_STATUS_HIGH_OFS 12'h174
`define MSI_MASK_LOW_OFS 12'h178
`define MSI_MASK_HIGH_OFS 12'h17c
`define EVT_STATUS_OFS 12'h180
`define EVT_MASK_OFS 12'h184
`define DECODE_CFG_OFS 12'h188

// ----------------------------------------
// field positions
// ----------------------------------------
`define LEGACY_LSB 16
`define LEGACY_MSB 19
`define ERR_UNCORR_BIT 0
`define ERR_CORR_BIT 1
`define EVT_MSI_BIT 0
`define EVT_LEGACY_BIT 1
`define EVT_UNCORR_BIT 2
`define EVT_CORR_BIT 3
`define CFG_DECODE_BIT 0
`define CFG_ROOT_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define WORD_RESET 32'h0000_0000
`define NIBBLE_RESET 4'h0
`define PAIR_RESET 2'h0

`endif

// ---- src/irq_decode_pkg.sv ----
package irq_decode_pkg;

	typedef struct packed {
		logic [31:0] status;
	} bank_state_t;

	typedef struct packed {
		logic [3:0] aer_uncorr_set;
		logic [3:0] aer_corr_set;
		logic err_msg_uncorr;
		logic err_msg_corr;
	} err_state_t;

	typedef struct packed {
		logic [3:0] legacy_status;
		logic [3:0] legacy_mask;
		logic [31:0] msi_mask_low;
		logic [31:0] msi_mask_high;
		logic [1:0] err_ctrl;
		logic [3:0] evt_status;
		logic [3:0] evt_mask;
		logic decode_en;
		logic [31:0] rdata;
		logic [31:0] msi_low_out;
		logic [31:0] msi_high_out;
		logic legacy_out;
		logic irq;
	} top_state_t;

	// sticky update, set wins over clear
	function automatic logic [31:0] w1c_update(input logic [31:0] cur,
		input logic [31:0] set, input logic [31:0] clr);
		w1c_update = (cur & ~clr) | set;
	endfunction

endpackage

// ---- src/msi_status_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module msi_status_bank (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// set and clear vectors
	input wire logic [31:0] set_vec,
	input wire logic [31:0] clr_vec,
	// pending vectors
	output logic [31:0] status
);

	irq_decode_pkg::bank_state_t state;
	irq_decode_pkg::bank_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.status = irq_decode_pkg::w1c_update(state.status, set_vec,
			clr_vec);
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state.status <= 32'h0000_0000;
		end else begin
			state <= next_state;
		end
	end

	assign status = state.status;

endmodule

`default_nettype wire

// ---- src/root_port_irq_decode_and_error_report.sv ----
// Behaviour
// - in decode mode the legacy mask picks which lines feed the aggregate.
// - legacy mask bits 16..19 enable lines a..d, other bits reserved.
// - the legacy mask and both msi masks reset to zero.
// - low msi status bit x is vector x pending, a written one clears it.
// - high msi status bit x is vector x+32 pending, a written one clears it.
// - msi status reads return zero when the core is not a root port.
// - in decode mode low msi mask bit x gates vector x on the low bus.
// - in decode mode high msi mask bit x gates vector x+32 on the high bus.
// - a one on control bit 0 sets uncorrectable status and messages.
// - a one on control bit 1 sets correctable status and messages.
// - each control bit stands one cycle after the write, then clears.
// - a legacy line status sets on assert and clears on deassert.
//
// The address-and-strobe port is this design's own decision.
`include "irq_decode_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module root_port_irq_decode_and_error_report (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// incoming interrupt messages
	input wire logic msg_valid,
	input wire logic msg_is_msi,
	input wire logic [5:0] msg_vector,
	input wire logic [1:0] msg_line,
	input wire logic msg_assert,
	// core configuration
	input wire logic root_port_mode,
	input wire logic [3:0] func_enable,
	input wire logic err_msg_enable,
	// decoded interrupt outputs
	output logic [31:0] msi_low_vector_output,
	output logic [31:0] msi_high_vector_output,
	output logic legacy_irq_out,
	output logic irq,
	// error reporting
	output wire logic [3:0] aer_uncorr_set,
	output wire logic [3:0] aer_corr_set,
	output wire logic err_msg_uncorr,
	output wire logic err_msg_corr
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	irq_decode_pkg::top_state_t state;
	irq_decode_pkg::top_state_t next_state;

	logic [31:0] msi_status_low;
	logic [31:0] msi_status_high;
	logic [31:0] msi_set_low;
	logic [31:0] msi_set_high;
	logic [31:0] msi_clr_low;
	logic [31:0] msi_clr_high;
	logic msi_msg;
	logic legacy_msg;
	logic [31:0] vec_onehot;

	// ----------------------------------------
	// write decode helper
	// ----------------------------------------
	function automatic logic wr_hit(input logic [11:0] ofs);
		wr_hit = reg_wr && (reg_addr == ofs);
	endfunction

	// ----------------------------------------
	// msi vector demux
	// ----------------------------------------
	always_comb begin
		msi_msg = msg_valid && msg_is_msi;
		legacy_msg = msg_valid && !msg_is_msi;
		vec_onehot = 32'h0000_0001 << msg_vector[4:0];
		msi_set_low = (msi_msg && !msg_vector[5]) ? vec_onehot
			: 32'h0000_0000;
		msi_set_high = (msi_msg && msg_vector[5]) ? vec_onehot
			: 32'h0000_0000;
		msi_clr_low = wr_hit(`MSI_STATUS_LOW_OFS) ? reg_wdata
			: 32'h0000_0000;
		msi_clr_high = wr_hit(`MSI_STATUS_HIGH_OFS) ? reg_wdata
			: 32'h0000_0000;
	end

	msi_status_bank low_bank (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.set_vec(msi_set_low),
		.clr_vec(msi_clr_low),
		.status(msi_status_low)
	);

	msi_status_bank high_bank (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.set_vec(msi_set_high),
		.clr_vec(msi_clr_high),
		.status(msi_status_high)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] evt_set;
		logic [31:0] evt_clr;
		logic [31:0] evt_next;
		evt_set = 32'h0000_0000;
		evt_clr = 32'h0000_0000;
		evt_next = 32'h0000_0000;
		next_state = state;

		// legacy line level follows assert and deassert messages
		if (legacy_msg) begin
			next_state.legacy_status[msg_line] = msg_assert;
		end

		// mask and config writes, reserved bits dropped
		if (wr_hit(`LEGACY_MASK_OFS)) begin
			next_state.legacy_mask =
				reg_wdata[`LEGACY_MSB:`LEGACY_LSB];
		end
		if (wr_hit(`MSI_MASK_LOW_OFS)) begin
			next_state.msi_mask_low = reg_wdata;
		end
		if (wr_hit(`MSI_MASK_HIGH_OFS)) begin
			next_state.msi_mask_high = reg_wdata;
		end
		if (wr_hit(`EVT_MASK_OFS)) begin
			next_state.evt_mask = reg_wdata[3:0];
		end
		if (wr_hit(`DECODE_CFG_OFS)) begin
			next_state.decode_en = reg_wdata[`CFG_DECODE_BIT];
		end

		// control bits live only in the cycle after the write
		next_state.err_ctrl = `PAIR_RESET;
		if (wr_hit(`ERR_CTRL_OFS)) begin
			next_state.err_ctrl = reg_wdata[1:0];
		end

		// event status, set wins over a same-cycle clear
		evt_set[`EVT_MSI_BIT] = msi_msg;
		evt_set[`EVT_LEGACY_BIT] = legacy_msg && msg_assert;
		evt_set[`EVT_UNCORR_BIT] = state.err_ctrl[`ERR_UNCORR_BIT];
		evt_set[`EVT_CORR_BIT] = state.err_ctrl[`ERR_CORR_BIT];
		if (wr_hit(`EVT_STATUS_OFS)) begin
			evt_clr = reg_wdata;
		end
		evt_next = irq_decode_pkg::w1c_update({28'h000_0000,
			state.evt_status}, evt_set, evt_clr);
		next_state.evt_status = evt_next[3:0];
		next_state.irq = |(evt_next[3:0] & next_state.evt_mask);

		// decoded outputs, all quiet outside decode mode
		if (state.decode_en) begin
			next_state.msi_low_out = msi_status_low
				& state.msi_mask_low;
			next_state.msi_high_out = msi_status_high
				& state.msi_mask_high;
			next_state.legacy_out = |(state.legacy_status
				& state.legacy_mask);
		end else begin
			next_state.msi_low_out = 32'h0000_0000;
			next_state.msi_high_out = 32'h0000_0000;
			next_state.legacy_out = 1'b0;
		end

		// read data stands only in the cycle after the strobe
		next_state.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`LEGACY_STATUS_OFS: begin
					if (root_port_mode) begin
						next_state.rdata[`LEGACY_MSB:`LEGACY_LSB] =
							state.legacy_status;
					end
				end
				`LEGACY_MASK_OFS: begin
					next_state.rdata[`LEGACY_MSB:`LEGACY_LSB] =
						state.legacy_mask;
				end
				`ERR_CTRL_OFS: begin
					next_state.rdata[1:0] = state.err_ctrl;
				end
				`MSI_STATUS_LOW_OFS: begin
					next_state.rdata = root_port_mode ? msi_status_low
						: 32'h0000_0000;
				end
				`MSI_STATUS_HIGH_OFS: begin
					next_state.rdata = root_port_mode ? msi_status_high
						: 32'h0000_0000;
				end
				`MSI_MASK_LOW_OFS: begin
					next_state.rdata = state.msi_mask_low;
				end
				`MSI_MASK_HIGH_OFS: begin
					next_state.rdata = state.msi_mask_high;
				end
				`EVT_STATUS_OFS: begin
					next_state.rdata[3:0] = state.evt_status;
				end
				`EVT_MASK_OFS: begin
					next_state.rdata[3:0] = state.evt_mask;
				end
				`DECODE_CFG_OFS: begin
					next_state.rdata[`CFG_DECODE_BIT] = state.decode_en;
					next_state.rdata[`CFG_ROOT_BIT] = root_port_mode;
				end
				default: begin
					next_state.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state.legacy_status <= `NIBBLE_RESET;
			state.legacy_mask <= `NIBBLE_RESET;
			state.msi_mask_low <= `WORD_RESET;
			state.msi_mask_high <= `WORD_RESET;
			state.err_ctrl <= `PAIR_RESET;
			state.evt_status <= `NIBBLE_RESET;
			state.evt_mask <= `NIBBLE_RESET;
			state.decode_en <= 1'b0;
			state.rdata <= `WORD_RESET;
			state.msi_low_out <= `WORD_RESET;
			state.msi_high_out <= `WORD_RESET;
			state.legacy_out <= 1'b0;
			state.irq <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// error reporting
	// ----------------------------------------
	internal_error_report err_report (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.uncorr_pulse(state.err_ctrl[`ERR_UNCORR_BIT]),
		.corr_pulse(state.err_ctrl[`ERR_CORR_BIT]),
		.func_enable(func_enable),
		.err_msg_enable(err_msg_enable),
		.aer_uncorr_set(aer_uncorr_set),
		.aer_corr_set(aer_corr_set),
		.err_msg_uncorr(err_msg_uncorr),
		.err_msg_corr(err_msg_corr)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = state.rdata;
	assign msi_low_vector_output = state.msi_low_out;
	assign msi_high_vector_output = state.msi_high_out;
	assign legacy_irq_out = state.legacy_out;
	assign irq = state.irq;

endmodule

`default_nettype wire

// ---- testbench/irq_decode_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module irq_decode_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// configuration
	input wire logic root_port_mode,
	input wire logic [3:0] func_enable,
	input wire logic err_msg_enable,
	// outputs
	input wire logic [31:0] msi_low_vector_output,
	input wire logic [31:0] msi_high_vector_output,
	input wire logic legacy_irq_out,
	input wire logic irq,
	input wire logic [3:0] aer_uncorr_set,
	input wire logic [3:0] aer_corr_set,
	input wire logic err_msg_uncorr,
	input wire logic err_msg_corr
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	wire logic err_wr = reg_wr && reg_addr == 12'h168;

	chk_uncorr_fanout: assert property (err_wr && reg_wdata[0] |-> ##2
		aer_uncorr_set == $past(func_enable) &&
		err_msg_uncorr == $past(err_msg_enable)) else $error("uncorr fanout");
	chk_corr_cause: assert property (aer_corr_set != 4'h0 || err_msg_corr
		|-> $past(err_wr && reg_wdata[1], 2)) else $error("corr no cause");
	chk_uncorr_once: assert property (aer_uncorr_set != 4'h0 |=>
		aer_uncorr_set == 4'h0 || $past(err_wr && reg_wdata[0], 2))
		else $error("uncorr pulse long");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("rdata not idle");
	chk_mask_rsvd: assert property ($past(reg_rd && reg_addr == 12'h164)
		|-> reg_rdata[15:0] == 16'h0 && reg_rdata[31:20] == 12'h0)
		else $error("legacy mask reserved");
	chk_ctrl_rsvd: assert property ($past(reg_rd && reg_addr == 12'h168)
		|-> reg_rdata[31:2] == 30'h0) else $error("ctrl reserved");
	chk_msi_nonroot: assert property ($past(reg_rd && !root_port_mode &&
		(reg_addr == 12'h170 || reg_addr == 12'h174)) |-> reg_rdata == 32'h0)
		else $error("non root read");
	chk_low_gate: assert property (reg_wr && reg_addr == 12'h178 &&
		reg_wdata == 32'h0 |-> ##2 msi_low_vector_output == 32'h0)
		else $error("low not gated");
	chk_high_gate: assert property (reg_wr && reg_addr == 12'h17c &&
		reg_wdata == 32'h0 |-> ##2 msi_high_vector_output == 32'h0)
		else $error("high not gated");
	chk_legacy_gate: assert property (reg_wr && reg_addr == 12'h164 &&
		reg_wdata[19:16] == 4'h0 |-> ##2 !legacy_irq_out)
		else $error("legacy not gated");

	cover property (err_wr && reg_wdata[0]);
	cover property (msi_high_vector_output != 32'h0);
	cover property (legacy_irq_out);
	cover property (irq);
endmodule

bind root_port_irq_decode_and_error_report irq_decode_assertions
	irq_decode_assertions_inst (.sys_clk(sys_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.root_port_mode(root_port_mode), .func_enable(func_enable),
	.err_msg_enable(err_msg_enable),
	.msi_low_vector_output(msi_low_vector_output),
	.msi_high_vector_output(msi_high_vector_output),
	.legacy_irq_out(legacy_irq_out), .irq(irq),
	.aer_uncorr_set(aer_uncorr_set), .aer_corr_set(aer_corr_set),
	.err_msg_uncorr(err_msg_uncorr), .err_msg_corr(err_msg_corr));

`default_nettype wire

// ---- testbench/irq_msg_source.sv ----
`timescale 1ns/1ps
`default_nettype none

module irq_msg_source (
	// clock
	input wire logic sys_clk,
	// message lines
	output logic msg_valid,
	output logic msg_is_msi,
	output logic [5:0] msg_vector,
	output logic [1:0] msg_line,
	output logic msg_assert
);
	initial begin
		msg_valid = 1'h0;
		msg_is_msi = 1'h0;
		msg_vector = 6'h00;
		msg_line = 2'h0;
		msg_assert = 1'h0;
	end

	// one-cycle message, then idle lines flipped
	task automatic send(input logic msi, input logic [5:0] vec,
		input logic [1:0] line, input logic asrt);
		@(posedge sys_clk);
		msg_valid <= 1'h1;
		msg_is_msi <= msi;
		msg_vector <= vec;
		msg_line <= line;
		msg_assert <= asrt;
		@(posedge sys_clk);
		msg_valid <= 1'h0;
		msg_is_msi <= ~msi;
		msg_vector <= ~vec;
		msg_line <= ~line;
		msg_assert <= ~asrt;
	endtask
endmodule

`default_nettype wire

// ---- testbench/test_root_port_irq_decode_and_error_report.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_root_port_irq_decode_and_error_report;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic root_port_mode = 1'h1;
	logic [3:0] func_enable = 4'h0;
	logic err_msg_enable = 1'h0;
	logic msg_valid, msg_is_msi, msg_assert, leg_out, irq, unc_msg, cor_msg;
	logic [5:0] msg_vector;
	logic [1:0] msg_line;
	logic [31:0] reg_rdata, lo_out, hi_out, slo, shi, m;
	logic [3:0] unc_set, cor_set, lst;
	logic [11:0] ofs [5] = '{12'h164, 12'h168, 12'h178, 12'h17c, 12'h190};
	int fails = 0;
	int checks_done = 0;
	int v;

	always #5 sys_clk = ~sys_clk;

	root_port_irq_decode_and_error_report
		root_port_irq_decode_and_error_report_inst (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .msg_valid(msg_valid),
		.msg_is_msi(msg_is_msi), .msg_vector(msg_vector),
		.msg_line(msg_line), .msg_assert(msg_assert),
		.root_port_mode(root_port_mode), .func_enable(func_enable),
		.err_msg_enable(err_msg_enable), .msi_low_vector_output(lo_out),
		.msi_high_vector_output(hi_out), .legacy_irq_out(leg_out),
		.irq(irq), .aer_uncorr_set(unc_set), .aer_corr_set(cor_set),
		.err_msg_uncorr(unc_msg), .err_msg_corr(cor_msg));

	irq_msg_source irq_msg_source_inst (.sys_clk(sys_clk),
		.msg_valid(msg_valid), .msg_is_msi(msg_is_msi),
		.msg_vector(msg_vector), .msg_line(msg_line),
		.msg_assert(msg_assert));

	// ------
	// helpers
	// ------
	function automatic logic [31:0] gate(input logic [31:0] s, k);
		return s & k;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 chk(n, reg_rdata, e);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_of_test;
	end

	// ------
	// scenarios
	// ------
	initial begin
		v = $urandom(17493);
		slo = 32'h0000_0000;
		shi = 32'h0000_0000;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'h1;
		foreach (ofs[i]) rd("reset", ofs[i], 32'h0000_0000);
		wr(12'h188, 32'h0000_0001);
		wr(12'h178, 32'h0000_0000);
		wr(12'h17c, 32'h0000_0000);
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 63 : (i == 1) ? 32 : (i == 2) ? 31 : $urandom % 64;
			irq_msg_source_inst.send(1'h1, v[5:0], 2'h0, 1'h0);
			if (v < 32) slo[v] = 1'h1;
			else shi[v - 32] = 1'h1;
		end
		chk("lo_off", lo_out, 32'h0000_0000);
		rd("slo", 12'h170, slo);
		rd("shi", 12'h174, shi);
		@(posedge sys_clk);
		root_port_mode <= 1'h0;
		rd("nr_lo", 12'h170, 32'h0000_0000);
		rd("nr_hi", 12'h174, 32'h0000_0000);
		rd("nr_leg", 12'h160, 32'h0000_0000);
		@(posedge sys_clk);
		root_port_mode <= 1'h1;
		m = $urandom;
		wr(12'h178, m);
		wr(12'h17c, ~m);
		tick(2);
		chk("lo_out", lo_out, gate(slo, m));
		chk("hi_out", hi_out, gate(shi, ~m));
		m = $urandom;
		wr(12'h170, m);
		slo = slo & ~m;
		rd("w1c_lo", 12'h170, slo);
		wr(12'h174, ~m);
		shi = shi & m;
		rd("w1c_hi", 12'h174, shi);
		wr(12'h164, 32'h0000_0000);
		for (int l = 0; l < 4; l++) begin
			irq_msg_source_inst.send(1'h0, 6'h00, l[1:0], 1'h1);
		end
		rd("leg_st", 12'h160, 32'h000f_0000);
		chk("leg_off", leg_out, 32'h0000_0000);
		m = $urandom | 32'h0001_0000;
		wr(12'h164, m);
		rd("leg_mask", 12'h164, m & 32'h000f_0000);
		irq_msg_source_inst.send(1'h0, 6'h00, 2'h1, 1'h0);
		lst = 4'hd;
		rd("leg_st2", 12'h160, {12'h000, lst, 16'h0000});
		chk("leg_out", leg_out, 32'(|(lst & m[19:16])));
		@(posedge sys_clk);
		func_enable <= 4'($urandom) | 4'h1;
		err_msg_enable <= 1'h1;
		wr(12'h168, 32'hffff_fffd);
		tick(1);
		chk("unc_set", unc_set, func_enable);
		chk("unc_msg", unc_msg, 32'h0000_0001);
		chk("cor_idle", cor_set, 32'h0000_0000);
		tick(1);
		chk("unc_clr", unc_set, 32'h0000_0000);
		@(posedge sys_clk);
		err_msg_enable <= 1'h0;
		wr(12'h168, 32'h0000_0002);
		tick(1);
		chk("cor_set", cor_set, func_enable);
		chk("cor_msg", cor_msg, 32'h0000_0000);
		@(posedge sys_clk);
		err_msg_enable <= 1'h1;
		wr(12'h168, 32'h0000_0003);
		tick(1);
		chk("cor_msg_on", cor_msg, 32'h0000_0001);
		chk("unc_msg_on", unc_msg, 32'h0000_0001);
		chk("cor_set_on", cor_set, func_enable);
		tick(1);
		chk("cor_clr", cor_set, 32'h0000_0000);
		chk("cor_msg_clr", cor_msg, 32'h0000_0000);
		wr(12'h184, 32'h0000_0004);
		tick(2);
		chk("irq_on", irq, 32'h0000_0001);
		wr(12'h180, 32'h0000_0004);
		tick(2);
		chk("irq_off", irq, 32'h0000_0000);
		wr(12'h184, 32'h0000_0001);
		tick(2);
		chk("irq_msi", irq, 32'h0000_0001);
		wr(12'h180, 32'h0000_000f);
		tick(2);
		chk("irq_clr", irq, 32'h0000_0000);
		end_of_test;
	end
endmodule

`default_nettype wire
